// file: tbcd_pkg.sv
// *****************************************************************************
// Shared constants and types of the transmit command A decoder.
// *****************************************************************************
package tbcd_pkg;

	// *************************************************************************
	// Command word field positions.
	// *************************************************************************
	localparam int TBCD_IOC_BIT = 31; // Completion notify request.
	localparam int TBCD_RSV_HI_MSB = 30; // Upper unused range, top bit.
	localparam int TBCD_RSV_HI_LSB = 26; // Upper unused range, bottom bit.
	localparam int TBCD_ALIGN_MSB = 25; // End alignment code, top bit.
	localparam int TBCD_ALIGN_LSB = 24; // End alignment code, bottom bit.
	localparam int TBCD_RSV_LO_MSB = 23; // Range under the alignment code, top bit.
	localparam int TBCD_RSV_LO_LSB = 21; // Range under the alignment code, bottom bit.
	localparam int TBCD_OFS_MSB = 20; // Data start offset, top bit.
	localparam int TBCD_OFS_LSB = 16; // Data start offset, bottom bit.
	localparam int TBCD_FS_BIT = 13; // First segment marker.
	localparam int TBCD_LS_BIT = 12; // Last segment marker.
	localparam int TBCD_SIZE_MSB = 10; // Buffer byte count, top bit.

	// *************************************************************************
	// End alignment codes and their word granularity as a power of two.
	// *************************************************************************
	localparam logic [1:0] TBCD_ALIGN_4 = 2'h0; // One word.
	localparam logic [1:0] TBCD_ALIGN_16 = 2'h1; // Four words.
	localparam logic [1:0] TBCD_ALIGN_32 = 2'h2; // Eight words.
	localparam logic [1:0] TBCD_ALIGN_RSV = 2'h3; // Reserved, handled as one word.
	localparam logic [1:0] TBCD_SHIFT_4 = 2'h0; // Log2 of words for 4 bytes.
	localparam logic [1:0] TBCD_SHIFT_16 = 2'h2; // Log2 of words for 16 bytes.
	localparam logic [1:0] TBCD_SHIFT_32 = 2'h3; // Log2 of words for 32 bytes.

	// *************************************************************************
	// Register map (byte addresses) and reset values.
	// *************************************************************************
	localparam logic [7:0] TBCD_CTRL_OFS = 8'h00; // Control: bit 0 enables intake.
	localparam logic [7:0] TBCD_STATUS_OFS = 8'h04; // Sticky events, cleared by read.
	localparam logic [7:0] TBCD_MASK_OFS = 8'h08; // Interrupt mask, same layout.
	localparam logic [7:0] TBCD_CMD_OFS = 8'h0c; // Last captured command word.
	localparam logic [7:0] TBCD_STATE_OFS = 8'h10; // State and word index.
	localparam logic TBCD_CTRL_RST = 1'b0; // Intake off after reset.
	localparam logic [2:0] TBCD_MASK_RST = 3'h0; // All events masked after reset.
	localparam int TBCD_EVT_DONE = 0; // Buffer fully loaded.
	localparam int TBCD_EVT_RSV = 1; // Bits of an unused range were not zero.
	localparam int TBCD_EVT_ALIGN = 2; // Reserved alignment code seen.
	localparam int TBCD_NEVT = 3; // Number of event bits.

	// *************************************************************************
	// Types.
	// *************************************************************************
	typedef enum logic [1:0] {
		TBCD_ST_CMD_A = 2'h0,
		TBCD_ST_CMD_B = 2'h1,
		TBCD_ST_DATA = 2'h3
	} tbcd_state_t;

	// Decoded first command word.
	typedef struct packed {
		logic ioc;
		logic [1:0] align;
		logic [4:0] offset;
		logic first_seg_bit;
		logic last_seg_bit;
		logic [10:0] size;
		logic [9:0] data_words;
		logic [9:0] total_words;
		logic [1:0] end_lane;
		logic rsv_err;
		logic align_err;
	} tbcd_cmd_t;

	// One payload word towards the transmit path.
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] be;
		logic first_seg_bit;
		logic last_seg_bit;
		logic sop;
		logic eob;
	} tbcd_beat_t;

	// Rounds a count up to a multiple of two to the power shift.
	function automatic logic [11:0] tbcd_round_up(input logic [11:0] cnt, input logic [1:0] shift);
		logic [11:0] m;
		m = (12'h001 << shift) - 12'h001;
		return (cnt + m) & ~m;
	endfunction

endpackage

// file: tbcd_cmd_decode.sv
`timescale 1ns/1ps
// *****************************************************************************
// Field decoder for the first command word of a transmit buffer.
// *****************************************************************************
module tbcd_cmd_decode
	import tbcd_pkg::*;
(
	// Raw word.
	input wire logic [31:0] cmd_word,
	// Decoded fields.
	output tbcd_cmd_t fields
);

	// Decodes the fields and derives the word counts of the buffer body.
	always_comb begin
		logic [11:0] bytes_total;
		logic [11:0] words;
		logic [1:0] shift;
		logic [11:0] total;
		bytes_total = 12'h000;
		words = 12'h000;
		total = 12'h000;
		shift = TBCD_SHIFT_4;
		fields.ioc = cmd_word[TBCD_IOC_BIT];
		fields.align = cmd_word[TBCD_ALIGN_MSB:TBCD_ALIGN_LSB];
		fields.offset = cmd_word[TBCD_OFS_MSB:TBCD_OFS_LSB];
		fields.first_seg_bit = cmd_word[TBCD_FS_BIT];
		fields.last_seg_bit = cmd_word[TBCD_LS_BIT];
		fields.size = cmd_word[TBCD_SIZE_MSB:0];
		// Both unused ranges must arrive as zero from the host.
		fields.rsv_err = (|cmd_word[TBCD_RSV_HI_MSB:TBCD_RSV_HI_LSB])
			| (|cmd_word[TBCD_RSV_LO_MSB:TBCD_RSV_LO_LSB]);
		fields.align_err = (fields.align == TBCD_ALIGN_RSV);
		// Alignment code to word granularity; the reserved code acts as 4-byte.
		case (fields.align)
			TBCD_ALIGN_16: shift = TBCD_SHIFT_16;
			TBCD_ALIGN_32: shift = TBCD_SHIFT_32;
			default: shift = TBCD_SHIFT_4;
		endcase
		// Offset bytes count as part of the body, so skipped words are included.
		bytes_total = {1'b0, fields.size} + {7'h00, fields.offset};
		words = tbcd_round_up(bytes_total, TBCD_SHIFT_16) >> 2;
		fields.data_words = words[9:0];
		fields.end_lane = bytes_total[1:0] - 2'h1;
		// The host pads the body up to the alignment; the total counts those words.
		// The largest body is 520 words, so ten bits always hold the total.
		total = tbcd_round_up(words, shift);
		fields.total_words = total[9:0];
	end

endmodule // tbcd_cmd_decode

// file: tbcd_decoder.sv
`timescale 1ns/1ps
module tbcd_decoder
	import tbcd_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock, reset and clock enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Word stream from the host side of the transmit data FIFO.
	input wire logic in_valid,
	input wire logic [31:0] in_data,
	output logic in_ready,
	// Payload stream towards the transmit path.
	output logic out_valid,
	input wire logic out_ready,
	output tbcd_beat_t out_beat,
	// Interrupt and completion flag.
	output logic irq,
	output logic tx_buffer_loaded_flag
);

	// *************************************************************************
	// State.
	// *************************************************************************
	typedef struct packed {
		tbcd_state_t st;
		tbcd_cmd_t cmd;
		logic [31:0] cmd_raw;
		logic [9:0] idx;
		logic out_valid;
		tbcd_beat_t beat;
		logic done;
		logic enable;
		logic [TBCD_NEVT-1:0] status;
		logic [TBCD_NEVT-1:0] mask;
		logic ack;
		logic [31:0] rdata;
		logic err;
	} tbcd_regs_t;

	tbcd_regs_t r_reg; // Registered state.
	tbcd_regs_t r_next; // Next value of the state.
	tbcd_cmd_t dec; // Fields of the word now on the input.
	logic take; // A word is taken this cycle.
	logic apb_go; // Access phase seen, answer next cycle.
	logic apb_done; // Transfer completes at this edge.

	// Decodes the word presented on the input; used only while it is the first word.
	tbcd_cmd_decode u_dec (
		.cmd_word(in_data),
		.fields(dec)
	);

	// *************************************************************************
	// Handshakes and outputs.
	// *************************************************************************
	// Input stalls while the output word waits; a frozen clock enable stalls all.
	assign in_ready = ce && r_reg.enable && (!r_reg.out_valid || out_ready);
	assign take = in_valid && in_ready;
	// Valid, ready and error are masked while frozen, so that no handshake completes then.
	assign out_valid = r_reg.out_valid && ce;
	assign out_beat = r_reg.beat;
	assign tx_buffer_loaded_flag = r_reg.done;
	assign pready = r_reg.ack && ce;
	assign prdata = r_reg.rdata;
	assign pslverr = r_reg.err && ce;
	assign apb_go = psel && penable && !r_reg.ack;
	assign apb_done = psel && penable && r_reg.ack && ce;
	// The mask bit of the loaded flag is its mapping onto the interrupt line.
	assign irq = |(r_reg.status & r_reg.mask);

	// Returns the read value of an address and whether it is mapped.
	function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] a, input tbcd_regs_t s);
		logic [7:0] a8;
		a8 = a[7:0];
		if (ADDR_W > 8 && (a >> 8) != '0) begin
			return {1'b1, 32'h00000000};
		end
		case (a8)
			TBCD_CTRL_OFS: return {1'b0, 31'h00000000, s.enable};
			TBCD_STATUS_OFS: return {1'b0, 29'h00000000, s.status};
			TBCD_MASK_OFS: return {1'b0, 29'h00000000, s.mask};
			TBCD_CMD_OFS: return {1'b0, s.cmd_raw};
			TBCD_STATE_OFS: return {1'b0, 14'h0000, s.st, 6'h00, s.idx};
			default: return {1'b1, 32'h00000000};
		endcase
	endfunction

	// *************************************************************************
	// Next state.
	// *************************************************************************
	// Sequences command words and body, and serves the register bus.
	always_comb begin
		logic [TBCD_NEVT-1:0] evt;
		logic [TBCD_NEVT-1:0] clr;
		logic [9:0] skip;
		logic payload;
		logic [32:0] rd;
		evt = '0;
		clr = '0;
		skip = {7'h00, r_reg.cmd.offset[4:2]};
		payload = 1'b0;
		rd = read_word(paddr, r_reg);
		r_next = r_reg;
		r_next.done = 1'b0;
		// A word that the sink took leaves the output stage.
		if (r_reg.out_valid && out_ready) begin
			r_next.out_valid = 1'b0;
		end
		case (r_reg.st)
			TBCD_ST_CMD_A: begin
				// The first word of each buffer is the command; its fields stay put.
				if (take) begin
					r_next.cmd = dec;
					r_next.cmd_raw = in_data;
					evt[TBCD_EVT_RSV] = dec.rsv_err;
					evt[TBCD_EVT_ALIGN] = dec.align_err;
					r_next.st = TBCD_ST_CMD_B;
				end
			end
			TBCD_ST_CMD_B: begin
				// The second word is passed over; an empty body ends the buffer here.
				if (take) begin
					r_next.idx = '0;
					if (r_reg.cmd.total_words == '0) begin
						r_next.st = TBCD_ST_CMD_A;
						r_next.done = r_reg.cmd.ioc;
						evt[TBCD_EVT_DONE] = r_reg.cmd.ioc;
					end else begin
						r_next.st = TBCD_ST_DATA;
					end
				end
			end
			TBCD_ST_DATA: begin
				// Words below the skip count and past the data are dropped.
				payload = (r_reg.idx >= skip) && (r_reg.idx < r_reg.cmd.data_words);
				if (take) begin
					if (payload) begin
						r_next.out_valid = 1'b1;
						r_next.beat.data = in_data;
						r_next.beat.sop = (r_reg.idx == skip);
						r_next.beat.eob = (r_reg.idx == r_reg.cmd.data_words - 10'h001);
						r_next.beat.be = 4'hf;
						// Low offset bits choose the first valid lane.
						if (r_reg.idx == skip) begin
							r_next.beat.be = 4'hf << r_reg.cmd.offset[1:0];
						end
						// The last data word carries only up to the final byte.
						if (r_next.beat.eob) begin
							r_next.beat.be = r_next.beat.be & (4'hf >> (2'h3 - r_reg.cmd.end_lane));
						end
						r_next.beat.first_seg_bit = r_reg.cmd.first_seg_bit;
						r_next.beat.last_seg_bit = r_reg.cmd.last_seg_bit;
					end
					// The buffer ends only with its last aligned word.
					if (r_reg.idx == r_reg.cmd.total_words - 10'h001) begin
						r_next.st = TBCD_ST_CMD_A;
						r_next.done = r_reg.cmd.ioc;
						evt[TBCD_EVT_DONE] = r_reg.cmd.ioc;
					end else begin
						r_next.idx = r_reg.idx + 10'h001;
					end
				end
			end
			default: begin
				r_next.st = TBCD_ST_CMD_A;
			end
		endcase
		// Two-cycle APB answer: the read data and pready are registered at the same edge, one cycle into the access phase.
		r_next.ack = apb_go;
		if (apb_go) begin
			r_next.rdata = pwrite ? 32'h00000000 : rd[31:0];
			r_next.err = rd[32];
		end else begin
			r_next.rdata = 32'h00000000;
			r_next.err = 1'b0;
		end
		if (apb_done && !r_reg.err) begin
			if (pwrite) begin
				if (paddr[7:0] == TBCD_CTRL_OFS) begin
					r_next.enable = pwdata[0];
				end
				if (paddr[7:0] == TBCD_MASK_OFS) begin
					r_next.mask = pwdata[TBCD_NEVT-1:0];
				end
			end else if (paddr[7:0] == TBCD_STATUS_OFS) begin
				// Only the bits that the read returned are cleared; a bit set after the
				// data was captured would otherwise be lost unseen.
				clr = r_reg.rdata[TBCD_NEVT-1:0];
			end
		end
		// A new event in the clearing cycle survives the read.
		r_next.status = (r_reg.status & ~clr) | evt;
	end

	// *************************************************************************
	// Registers.
	// *************************************************************************
	// All state is held while the clock enable is low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.st <= TBCD_ST_CMD_A;
			r_reg.enable <= TBCD_CTRL_RST;
			r_reg.mask <= TBCD_MASK_RST;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

endmodule // tbcd_decoder

// file: tbcd_chk.sv
`timescale 1ns/1ps
// ****
// Port checker of the transmit command decoder.
// ****
module tbcd_chk
	import tbcd_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock, reset and clock enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Streams and flags.
	input wire logic in_valid,
	input wire logic [31:0] in_data,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire tbcd_beat_t out_beat,
	input wire logic irq,
	input wire logic tx_buffer_loaded_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_wait_a: assert property (psel && penable && !pready && ce |=> pready)
		else $error("pready late");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	flag_pulse_a: assert property (tx_buffer_loaded_flag && ce |=> !tx_buffer_loaded_flag)
		else $error("loaded flag too long");
	flag_cause_a: assert property (tx_buffer_loaded_flag && $past(ce)
		|-> $past(in_valid && in_ready))
		else $error("loaded flag without intake");
	// A stalled beat must not change, or a payload byte would be lost.
	beat_hold_a: assert property (out_valid && !out_ready
		|=> (out_valid || !ce) && $stable(out_beat))
		else $error("beat changed while stalled");
	// A one-word payload may also end early, so its lanes are any contiguous run.
	sop_lane_a: assert property (out_valid && out_beat.sop |-> out_beat.be inside {4'hf, 4'he, 4'hc, 4'h8}
		|| (out_beat.eob && out_beat.be inside {4'h1, 4'h2, 4'h4, 4'h3, 4'h6, 4'h7}))
		else $error("bad first lanes");
	mid_lane_a: assert property (out_valid && !out_beat.sop && !out_beat.eob |-> out_beat.be == 4'hf)
		else $error("bad middle lanes");
	end_lane_a: assert property (out_valid && out_beat.eob && !out_beat.sop |-> out_beat.be inside {4'h1, 4'h3, 4'h7, 4'hf})
		else $error("bad last lanes");
	intake_gate_a: assert property (in_ready |-> ce && (!out_valid || out_ready))
		else $error("intake while full");
	irq_rise_a: assert property ($rose(irq) |-> $past(in_valid && in_ready) || $past(pready))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(pready))
		else $error("irq fell without access");
endmodule // tbcd_chk

bind tbcd_decoder tbcd_chk #(.ADDR_W(ADDR_W)) chk (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
	.in_data(in_data), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
	.out_beat(out_beat), .irq(irq), .tx_buffer_loaded_flag(tx_buffer_loaded_flag));

// file: tbcd_host_model.sv
`timescale 1ns/1ps
// ****
// Host model: writes command and body words into the stream.
// ****
module tbcd_host_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Word stream.
	output logic in_valid,
	output logic [31:0] in_data,
	input wire logic in_ready
);
	initial begin
		in_valid = 1'b0;
		in_data = 32'h0;
	end
	// Body word i carries its own byte numbers, so a lost or moved byte shows.
	function automatic logic [31:0] word(input int i);
		logic [5:0] k;
		k = 6'(i);
		return {k, 2'h3, k, 2'h2, k, 2'h1, k, 2'h0};
	endfunction
	// Offers one word and holds it until taken; idle data is inverted.
	task automatic put(input logic [31:0] w, input int gap);
		if (gap > 0) begin
			in_valid <= 1'b0;
			in_data <= ~in_data;
			repeat (gap) @(posedge pclk);
		end
		in_valid <= 1'b1;
		in_data <= w;
		@(posedge pclk);
		while (!in_ready) @(posedge pclk);
	endtask
	// Sends a whole buffer: command pair, body and end padding.
	task automatic send_buf(input logic [31:0] cmd, input int gap);
		int t;
		int a;
		t = (cmd[20:16] + cmd[10:0] + 3) / 4;
		a = (cmd[25:24] == 2'h1) ? 4 : (cmd[25:24] == 2'h2) ? 8 : 1;
		t = (t + a - 1) / a * a;
		put(cmd & 32'h831fffff, gap);
		put(32'h0, gap);
		for (int i = 0; i < t; i++) put(word(i), gap);
		in_valid <= 1'b0;
		in_data <= ~in_data;
		@(posedge pclk);
	endtask
endmodule // tbcd_host_model

// file: test_tbcd_decoder.sv
`timescale 1ns/1ps
module test_tbcd_decoder import tbcd_pkg::*;;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic in_valid, in_ready, out_valid, out_ready, irq, flag, stall, msk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, in_data, r;
	logic e;
	tbcd_beat_t out_beat;
	tbcd_beat_t q[$];
	int mismatches, n_compared, nflag;
	tbcd_decoder dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data),
		.in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
		.out_beat(out_beat), .irq(irq), .tx_buffer_loaded_flag(flag));
	tbcd_host_model host (.pclk(pclk), .presetn(presetn), .in_valid(in_valid),
		.in_data(in_data), .in_ready(in_ready));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Far side stalls every other cycle when asked to; the clock enable then
	// also drops for one cycle after each accepted beat.
	always @(posedge pclk) begin
		out_ready <= stall ? ~out_ready : 1'b1;
		ce <= !(stall && out_valid && out_ready);
		if (out_valid && out_ready) q.push_back(out_beat);
		if (flag && ce) nflag++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One APB transfer; waits for pready, only the watchdog ends a hang.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Sends one buffer and checks every payload beat, the flag and the irq.
	task automatic run(input logic ioc, input logic [1:0] al, input int ofs, input int sz,
		input logic fs, input int gap);
		int w0, nw, n, w, q0, f0;
		logic [3:0] be;
		logic [31:0] m;
		w0 = ofs / 4;
		nw = (ofs + sz + 3) / 4 - w0;
		n = 0;
		q0 = q.size();
		f0 = nflag;
		stall <= (gap % 2) == 1;
		host.send_buf({ioc, 5'h0, al, 3'h0, 5'(ofs), 2'h0, fs, ~fs, 1'b0, 11'(sz)}, gap);
		while (q.size() - q0 < nw && n < 200) begin
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
		chk(q.size() - q0, nw);
		for (int k = 0; k < q.size() - q0 && k < nw; k++) begin
			w = w0 + k;
			for (int j = 0; j < 4; j++) be[j] = (4 * w + j >= ofs) && (4 * w + j < ofs + sz);
			m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			chk(q[q0 + k].be, be);
			chk(q[q0 + k].data & m, host.word(w) & m);
			chk({q[q0 + k].sop, q[q0 + k].eob}, {k == 0, k == nw - 1});
			chk({q[q0 + k].first_seg_bit, q[q0 + k].last_seg_bit}, {fs, ~fs});
		end
		chk(nflag - f0, ioc);
		chk(irq, ioc & msk);
		if (ioc && !msk) begin
			apb(1'b1, TBCD_MASK_OFS, 32'h1);
			msk = 1'b1;
			chk(irq, 1'b1);
		end
		apb(1'b0, TBCD_STATUS_OFS, 32'h0);
		chk(r, {29'h0, al == 2'h3, 1'b0, ioc});
		chk(irq, 1'b0);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, stall, msk} = '0;
		mismatches = 0;
		n_compared = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, then an unmapped place that must be refused.
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4 + (i / 5) * 12), 32'h0);
			chk(r, 32'h0);
			chk(e, i == 5);
		end
		apb(1'b1, TBCD_CTRL_OFS, 32'h1);
		// Every alignment code, offset edges, stalls on both sides.
		run(1'b1, 2'h0, 0, 7, 1'b1, 0);
		run(1'b1, 2'h1, 5, 13, 1'b0, 1);
		run(1'b0, 2'h2, 31, 1, 1'b1, 0);
		run(1'b1, 2'h3, 2, 9, 1'b0, 2);
		run(1'b1, 2'h2, 8, 40, 1'b1, 1);
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		print_verdict();
	end
endmodule // test_tbcd_decoder
